// ---- verilog/gpi_consts.vh ----
// Constants for the general purpose pin interface
`ifndef GPI_CONSTS_VH
`define GPI_CONSTS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define GPI_NPIN        32
`define GPI_AW          12
`define GPI_SYNC_DEPTH  2

// ----------------------------------------------------------------------
// Register map (byte addresses, and region codes of addr[11:7])
// ----------------------------------------------------------------------
`define GPI_REGION_CTL   5'h00
`define GPI_REGION_CTL2  5'h0A
`define GPI_ADDR_INPUT   12'h300
`define GPI_ADDR_OUTPUT  12'h380
`define GPI_ADDR_STATUS  12'h400
`define GPI_ADDR_MASK    12'h404

// ----------------------------------------------------------------------
// Pin control register fields
// ----------------------------------------------------------------------
`define GPI_F_PULL_LO    0
`define GPI_F_PULL_HI    1
`define GPI_F_PGS_LO     2
`define GPI_F_PGS_HI     3
`define GPI_F_DET_LO     4
`define GPI_F_DET_HI     7
`define GPI_F_ODRAIN     8
`define GPI_F_DIR        9
`define GPI_F_OSEL       10
`define GPI_F_POL        11
`define GPI_F_MUX_LO     12
`define GPI_F_MUX_HI     13
`define GPI_F_OUT        16
`define GPI_F_IN         24
`define GPI_CTL_WMASK    32'h00013FFF
`define GPI_CTL_RESET    32'h00000040

// Pin control register 2 fields
`define GPI_F_SLEW       0
`define GPI_F_DRV_LO     4
`define GPI_F_DRV_HI     5
`define GPI_CTL2_WMASK   8'h31
`define GPI_CTL2_RESET   8'h00

// ----------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------
`define GPI_DET_LOW      4'h0
`define GPI_DET_HIGH     4'h1
`define GPI_DET_OFF      4'h4
`define GPI_DET_RISE     4'hD
`define GPI_DET_FALL     4'hE
`define GPI_DET_BOTH     4'hF
`define GPI_PULL_UP      2'h1
`define GPI_PULL_DOWN    2'h2
`define GPI_PGS_VCC      2'h1
`define GPI_PGS_OFF_A    2'h2
`define GPI_PGS_OFF_B    2'h3
`define GPI_MUX_GPIO     2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define GPI_CLK_PERIOD_NS  8
`define GPI_MIN_PULSE_NS   5

`endif

// ---- verilog/gpi_pin.v ----
// One pin slice: input synchroniser, event detection and pad drive
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"

module gpi_pin (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // Pad
   input  wire        pad_i,
   output wire        pad_o,
   output wire        pad_oe,
   // Configuration
   input  wire [31:0] ctl,
   input  wire        grp_out,
   input  wire        vcc_ok,
   // Alternate functions 1..3
   input  wire [2:0]  alt_o,
   input  wire [2:0]  alt_oe,
   // Status
   output wire        in_sync,
   output wire        event_p,
   output wire        wake_async
);

   reg  [`GPI_SYNC_DEPTH-1:0] sync_q;
   reg                        prev_q;
   wire [3:0]                 det;
   wire [1:0]                 power_gating_select;
   wire [1:0]                 mux;
   wire                       pol;
   wire                       cur;
   wire                       last;
   wire                       raw;
   wire                       gpio_val;
   wire                       drv_val;
   wire                       drv_en;
   wire                       gated;

   assign det = ctl[`GPI_F_DET_HI:`GPI_F_DET_LO];
   assign power_gating_select = ctl[`GPI_F_PGS_HI:`GPI_F_PGS_LO];
   assign mux = ctl[`GPI_F_MUX_HI:`GPI_F_MUX_LO];
   assign pol = ctl[`GPI_F_POL];

   // Two-stage synchroniser plus history flop for edges
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_q <= {`GPI_SYNC_DEPTH{1'b0}};
         prev_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[`GPI_SYNC_DEPTH-2:0], pad_i};
         prev_q <= sync_q[`GPI_SYNC_DEPTH-1];
      end
   end

   // Pad level always visible, whatever the mux says
   assign in_sync = sync_q[`GPI_SYNC_DEPTH-1];

   // Detection on polarity-corrected values, mux not consulted
   assign cur  = in_sync ^ pol;
   assign last = prev_q ^ pol;
   assign event_p = ((det == `GPI_DET_LOW)  & ~cur)          |
                    ((det == `GPI_DET_HIGH) &  cur)          |
                    ((det == `GPI_DET_RISE) &  cur & ~last)  |
                    ((det == `GPI_DET_FALL) & ~cur &  last)  |
                    ((det == `GPI_DET_BOTH) & (cur ^ last));

   // Clockless edge term: raw pad against last sampled level.
   // Holds while clocks are stopped, so a sleeping chip still sees it.
   assign raw = pad_i ^ pol;
   assign wake_async = ((det == `GPI_DET_RISE) &  raw & ~cur) |
                       ((det == `GPI_DET_FALL) & ~raw &  cur) |
                       ((det == `GPI_DET_BOTH) & (raw ^ cur));

   // Output source and drive type
   assign gpio_val = (ctl[`GPI_F_OSEL] ? grp_out : ctl[`GPI_F_OUT]) ^ pol;
   assign drv_val  = (mux == `GPI_MUX_GPIO) ? gpio_val : alt_o[mux - 2'h1];
   assign drv_en   = (mux == `GPI_MUX_GPIO) ? ctl[`GPI_F_DIR] : alt_oe[mux - 2'h1];

   // Emulated VCC gating floats the pad while the main rail is off
   assign gated = (power_gating_select == `GPI_PGS_OFF_A) | (power_gating_select == `GPI_PGS_OFF_B) |
                  ((power_gating_select == `GPI_PGS_VCC) & ~vcc_ok);

   // Open drain only ever drives low
   assign pad_o  = ctl[`GPI_F_ODRAIN] ? 1'b0 : drv_val;
   assign pad_oe = ~gated & drv_en & (~ctl[`GPI_F_ODRAIN] | ~drv_val);

endmodule
`default_nettype wire

// ---- verilog/gpi_top.v ----
// General purpose pin interface: register file, pin slices, interrupt
//
// Functional notes
// - Synchronise every pad input before use, except the raw pad in the clockless wake term
// - Per-pin event on level or edge
// - Pin event usable as wake event
// - Edge wake detected without a clock
// - Pad input readable under alternate function
// - Event detection works for every function
// - Per-pin or grouped data control
// - Control selects mux, direction, pull, gating, event
// - Push-pull or open-drain output per pin
// - Per-pin drive strength and slew
// - System reset, alternate main-rail reset
// - Select bit picks grouped or individual output
// - Individual output bit reads programmed value
// - Input bits always show pad state
// - Grouped output is 32-bit register
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"

module gpi_top (
   // Clock and resets
   input  wire                    clk_sys,
   input  wire                    rst_n,
   input  wire                    rst_vcc_n,
   // Register port
   input  wire [`GPI_AW-1:0]      addr,
   input  wire [31:0]             wdata,
   input  wire                    wr,
   input  wire                    rd,
   output reg  [31:0]             rdata,
   // Pads
   input  wire [`GPI_NPIN-1:0]    pad_i,
   output wire [`GPI_NPIN-1:0]    pad_o,
   output wire [`GPI_NPIN-1:0]    pad_oe,
   output wire [`GPI_NPIN-1:0]    pad_pu,
   output wire [`GPI_NPIN-1:0]    pad_pd,
   output wire [`GPI_NPIN-1:0]    pad_slew,
   output wire [2*`GPI_NPIN-1:0]  pad_drv,
   // Alternate functions
   input  wire [3*`GPI_NPIN-1:0]  alt_o,
   input  wire [3*`GPI_NPIN-1:0]  alt_oe,
   output wire [`GPI_NPIN-1:0]    alt_i,
   // Events
   output wire                    irq,
   output wire                    wake
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   reg  [31:0]            ctl_q  [0:`GPI_NPIN-1];
   reg  [7:0]             ctl2_q [0:`GPI_NPIN-1];
   reg  [`GPI_NPIN-1:0]   out_q;
   reg  [`GPI_NPIN-1:0]   sts_q;
   reg  [`GPI_NPIN-1:0]   msk_q;
   wire [`GPI_NPIN-1:0]   in_sync;
   wire [`GPI_NPIN-1:0]   event_p;
   wire [`GPI_NPIN-1:0]   wake_async;
   wire [`GPI_NPIN-1:0]   vcc_pin;
   wire [`GPI_NPIN-1:0]   sts_clr;
   wire [4:0]             region;
   wire [4:0]             idx;
   wire                   hit_ctl;
   wire                   hit_ctl2;
   integer                k;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   assign region   = addr[11:7];
   assign idx      = addr[6:2];
   assign hit_ctl  = (region == `GPI_REGION_CTL);
   assign hit_ctl2 = (region == `GPI_REGION_CTL2);

   // Pins whose outputs follow the main rail reset
   genvar g;
   generate
      for (g = 0; g < `GPI_NPIN; g = g + 1) begin : g_vcc
         assign vcc_pin[g] = (ctl_q[g][`GPI_F_PGS_HI:`GPI_F_PGS_LO] == `GPI_PGS_VCC);
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   // Main reset returns every register here to its reset value (control to 0x40); the alternate reset only clears the
   // output data of pins placed on the emulated VCC rail
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         for (k = 0; k < `GPI_NPIN; k = k + 1) begin
            ctl_q[k]  <= `GPI_CTL_RESET;
            ctl2_q[k] <= `GPI_CTL2_RESET;
         end
         out_q <= {`GPI_NPIN{1'b0}};
         msk_q <= {`GPI_NPIN{1'b0}};
      end else begin
         if (wr && hit_ctl) begin
            ctl_q[idx] <= wdata & `GPI_CTL_WMASK;
         end
         if (wr && hit_ctl2) begin
            ctl2_q[idx] <= wdata[7:0] & `GPI_CTL2_WMASK;
         end
         if (wr && addr == `GPI_ADDR_OUTPUT) begin
            out_q <= wdata;
         end
         if (wr && addr == `GPI_ADDR_MASK) begin
            msk_q <= wdata;
         end
         if (!rst_vcc_n) begin
            out_q <= out_q & ~vcc_pin;
            for (k = 0; k < `GPI_NPIN; k = k + 1) begin
               if (vcc_pin[k]) begin
                  ctl_q[k][`GPI_F_OUT] <= 1'b0;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------------
   assign sts_clr = (wr && addr == `GPI_ADDR_STATUS) ? wdata : {`GPI_NPIN{1'b0}};

   // Sticky bits; a new event beats a clear in the same cycle
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         sts_q <= {`GPI_NPIN{1'b0}};
      end else begin
         sts_q <= (sts_q & ~sts_clr) | event_p;
      end
   end

   // Level interrupt while any unmasked bit is set
   assign irq = |(sts_q & msk_q);

   // Wake also takes the clockless edge term, so a stopped clock
   // does not hide the edge that should restart it
   assign wake = |((sts_q | wake_async) & msk_q);

   // ----------------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         if (hit_ctl) begin
            // Output bit reads the programmed value, input bit the pad
            rdata <= ctl_q[idx] | ({31'h00000000, in_sync[idx]} << `GPI_F_IN);
         end else if (hit_ctl2) begin
            rdata <= {24'h000000, ctl2_q[idx]};
         end else if (addr == `GPI_ADDR_INPUT) begin
            rdata <= in_sync;
         end else if (addr == `GPI_ADDR_OUTPUT) begin
            rdata <= out_q;
         end else if (addr == `GPI_ADDR_STATUS) begin
            rdata <= sts_q;
         end else if (addr == `GPI_ADDR_MASK) begin
            rdata <= msk_q;
         end else begin
            rdata <= 32'h00000000;                             // Unmapped
         end
      end else begin
         rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------
   // Pin slices
   // ----------------------------------------------------------------------
   generate
      for (g = 0; g < `GPI_NPIN; g = g + 1) begin : g_pin
         gpi_pin u_pin (
            .clk_sys    (clk_sys),
            .rst_n      (rst_n),
            .pad_i      (pad_i[g]),
            .pad_o      (pad_o[g]),
            .pad_oe     (pad_oe[g]),
            .ctl        (ctl_q[g]),
            .grp_out    (out_q[g]),
            .vcc_ok     (rst_vcc_n),
            .alt_o      (alt_o[3*g+2:3*g]),
            .alt_oe     (alt_oe[3*g+2:3*g]),
            .in_sync    (in_sync[g]),
            .event_p    (event_p[g]),
            .wake_async (wake_async[g])
         );
         // Pad conditioning straight from the registers
         assign pad_pu[g]   = (ctl_q[g][`GPI_F_PULL_HI:`GPI_F_PULL_LO] == `GPI_PULL_UP);
         assign pad_pd[g]   = (ctl_q[g][`GPI_F_PULL_HI:`GPI_F_PULL_LO] == `GPI_PULL_DOWN);
         assign pad_slew[g] = ctl2_q[g][`GPI_F_SLEW];
         assign pad_drv[2*g+1:2*g] = ctl2_q[g][`GPI_F_DRV_HI:`GPI_F_DRV_LO];
      end
   endgenerate

   // Alternate functions see the synchronised pad level
   assign alt_i = in_sync;

endmodule
`default_nettype wire

// ---- sim/gpi_top_asserts.sv ----
// Checker for the pin interface top ports
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"
module gpi_chk (
   // Clock and resets
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire logic                   rst_vcc_n,
   // Register port
   input wire logic [`GPI_AW-1:0]     addr,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire logic [31:0]            rdata,
   // Pads and events
   input wire logic [`GPI_NPIN-1:0]   pad_i,
   input wire logic [`GPI_NPIN-1:0]   pad_oe,
   input wire logic [`GPI_NPIN-1:0]   pad_pu,
   input wire logic [`GPI_NPIN-1:0]   pad_pd,
   input wire logic [`GPI_NPIN-1:0]   pad_slew,
   input wire logic [2*`GPI_NPIN-1:0] pad_drv,
   input wire logic [`GPI_NPIN-1:0]   alt_i,
   input wire logic                   irq,
   input wire logic                   wake
);
   reg [1:0] up_q;
   reg       wrote_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Age since reset; synchroniser history is stale before 3
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         up_q <= 2'h0;
         wrote_q <= 1'b0;
      end else begin
         if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
         if (wr)
            wrote_q <= 1'b1;
      end
   end
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_input_read: assert property (rd && addr == `GPI_ADDR_INPUT |=> rdata == $past(alt_i))
      else $error("input register differs from synced pads");
   a_sync_depth: assert property (up_q == 2'h3 |-> alt_i == $past(pad_i, 2))
      else $error("pad input not two stage synchronised");
   a_wake_async_src: assert property (wake && !irq |-> pad_i != alt_i)
      else $error("wake without status or unsynced pad edge");
   a_irq_cause: assert property ($rose(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3)
      || $past(alt_i) != $past(alt_i, 2))
      else $error("interrupt rose without cause");
   a_irq_fall: assert property ($fell(irq) |-> $past(wr))
      else $error("interrupt fell without a write");
   a_quiet_reset: assert property (!wrote_q |-> pad_oe == '0 && pad_pu == '0 && !irq)
      else $error("pins active before any write");
   a_drv_static: assert property (!$stable(pad_drv) || !$stable(pad_slew) |-> $past(wr))
      else $error("drive settings moved without a write");
   a_pull_static: assert property (rst_vcc_n && $past(rst_vcc_n)
      && (!$stable(pad_pu) || !$stable(pad_pd)) |-> $past(wr))
      else $error("pull settings moved without a write");
   // Main scenarios reached
   cover property ($rose(irq));
   cover property (wake && !irq);
   cover property (rd && addr == `GPI_ADDR_INPUT);
endmodule
bind gpi_top gpi_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .rst_vcc_n(rst_vcc_n),
   .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .pad_i(pad_i), .pad_oe(pad_oe),
   .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_slew(pad_slew), .pad_drv(pad_drv),
   .alt_i(alt_i), .irq(irq), .wake(wake));
`default_nettype wire

// ---- sim/gpi_pads.sv ----
// Board model: pad levels from device drive, board drive and pulls
`timescale 1ns/1ns
`default_nettype none
module gpi_pads (
   // Clock for the floating pattern
   input  wire logic        clk_sys,
   // Device side
   input  wire logic [31:0] pad_o,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] pad_pu,
   input  wire logic [31:0] pad_pd,
   // Board drive
   input  wire logic [31:0] ext_v,
   input  wire logic [31:0] ext_en,
   output wire logic [31:0] pad_i
);
   reg [31:0] flt_q = 32'h0;
   // Undriven, unpulled pins wander so stale values never pass
   always @(posedge clk_sys)
      flt_q <= ~flt_q;
   // Board levels pass unfiltered, with no hold or pulse stretching
   assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_v)
      | (~pad_oe & ~ext_en & (pad_pu | (~pad_pd & flt_q)));
endmodule
`default_nettype wire

// ---- sim/gpi_top_tb.sv ----
// Self-checking bench for the pin interface top
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"
module gpi_top_tb;
   logic clk_sys = 0, rst_n = 0, rst_vcc_n = 1, wr = 0, rd = 0, irq, wake;
   logic [11:0] addr = 0;
   logic [31:0] wdata = 0, rdata, d, pad_i, pad_o, pad_oe, pad_pu, pad_pd, pad_slew, alt_i;
   logic [31:0] ext_v = 0, ext_en = '1;
   logic [63:0] pad_drv;
   logic [95:0] alt_o = 0, alt_oe = 0;
   int fail_count = 0, checks = 0, cyc = 0;
   gpi_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .rst_vcc_n(rst_vcc_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pad_i(pad_i), .pad_o(pad_o),
      .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_slew(pad_slew),
      .pad_drv(pad_drv), .alt_o(alt_o), .alt_oe(alt_oe), .alt_i(alt_i), .irq(irq),
      .wake(wake));
   gpi_pads pads_u (.clk_sys(clk_sys), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
      .pad_pd(pad_pd), .ext_v(ext_v), .ext_en(ext_en), .pad_i(pad_i));
   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // Bus, compare and closing tasks
   // ------------------------------------------------------------
   task wr_reg(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk_sys) {wr, addr, wdata} <= {1'b1, a, v};
      @(posedge clk_sys) wr <= 1'b0;
      #1;
   endtask
   task rd_reg(input logic [11:0] a);
      @(posedge clk_sys) {rd, addr} <= {1'b1, a};
      @(posedge clk_sys) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         give_verdict;
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd_reg(12'h000); chk(d, 32'h40);
      rd_reg(`GPI_ADDR_OUTPUT); chk(d, 32'h0);
      rd_reg(`GPI_ADDR_MASK); chk(d, 32'h0);
      rd_reg(12'h200); chk(d, 32'h0);
   endtask
   task t_output;
      wr_reg(12'h00C, 32'h00010200); chk(32'(pad_oe[3] & pad_o[3]), 1);
      wr_reg(12'h00C, 32'h00010300); chk(32'(pad_oe[3]), 0);
      // Released pad needs two edges through the synchroniser before bit 24 settles
      repeat (2) @(posedge clk_sys);
      rd_reg(12'h00C); chk(d, 32'h00010300);
      wr_reg(12'h00C, 32'h00010600); chk(32'(pad_o[3]), 0);
      wr_reg(`GPI_ADDR_OUTPUT, 32'h8); chk(32'(pad_o[3]), 1);
      rd_reg(`GPI_ADDR_OUTPUT); chk(d, 32'h8);
      wr_reg(12'h00C, 32'h00010604);
      @(posedge clk_sys) rst_vcc_n <= 1'b0;
      #1 chk(32'(pad_oe[3]), 0);
      @(posedge clk_sys) rst_vcc_n <= 1'b1;
      rd_reg(`GPI_ADDR_OUTPUT); chk(d, 32'h0);
      wr_reg(12'h00C, 32'h40);
   endtask
   task t_alt_drive;
      @(posedge clk_sys) {alt_o[15], alt_oe[15]} <= 2'b11;
      wr_reg(12'h014, 32'h00001040); chk(32'(pad_oe[5] & pad_o[5]), 1);
      repeat (3) @(posedge clk_sys);
      rd_reg(`GPI_ADDR_INPUT); chk(d & 32'h20, 32'h20);
      wr_reg(12'h508, '1); chk({pad_slew[2], pad_drv[5:4]}, 32'h7);
      rd_reg(12'h508); chk(d, 32'h31);
      // Pin 6 left to its pulls once the board lets go
      wr_reg(12'h018, 32'h41); chk({pad_pu[6], pad_pd[6]}, 2'b10);
      @(posedge clk_sys) ext_en[6] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd_reg(`GPI_ADDR_INPUT); chk(d & 32'h40, 32'h40);
      wr_reg(12'h018, 32'h42); chk({pad_pu[6], pad_pd[6]}, 2'b01);
      repeat (3) @(posedge clk_sys);
      rd_reg(`GPI_ADDR_INPUT); chk(d & 32'h40, 32'h0);
   endtask
   task t_events;
      logic [31:0] cv [6];
      logic st [6];
      logic lv [6];
      cv = '{32'h1000, 32'h1010, 32'h10D0, 32'h10E0, 32'h10F0, 32'h1810};
      st = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      lv = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys) ext_v[7] <= st[i];
         wr_reg(12'h01C, cv[i]);
         wr_reg(`GPI_ADDR_MASK, 32'h80);
         repeat (4) @(posedge clk_sys);
         wr_reg(`GPI_ADDR_STATUS, '1);
         rd_reg(`GPI_ADDR_STATUS); chk(d & 32'h80, 0);
         // Pulse held far beyond the minimum width
         @(posedge clk_sys) ext_v[7] <= ~st[i];
         #1 if (!lv[i]) chk(32'(wake), 1);
         repeat (4) @(posedge clk_sys);
         rd_reg(`GPI_ADDR_STATUS); chk(d & 32'h80, 32'h80);
         chk(32'(irq), 1);
         wr_reg(`GPI_ADDR_STATUS, 32'h80);
         rd_reg(`GPI_ADDR_STATUS); chk(d & 32'h80, {24'h0, lv[i], 7'h0});
         wr_reg(`GPI_ADDR_MASK, 0); chk(32'(irq), 0);
      end
   endtask
   // Main sequence: reset 20 cycles, then each scenario
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset;
      t_output;
      t_alt_drive;
      t_events;
      give_verdict;
   end
endmodule
`default_nettype wire
